// File: verilog/fpb_pkg.sv
// Shared constants and types of the front panel button and indicator block
package fpb_pkg;
  // Time base: one tick per millisecond
  localparam int CLK_MHZ  = 250;
  localparam int TICK_US  = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  // Durations, all in milliseconds (ticks)
  localparam int T_DEBOUNCE_MS = 20;
  localparam int T_BAND_SHORT_MS = 5000;
  localparam int T_BAND_LONG_MS  = 10000;
  localparam int T_SETUP_PRESS_MS = 2000;
  localparam int T_RESTORE_MS  = 10000;
  localparam int T_RECOVERY_MS = 60000;
  localparam int T_WINDOW_MS   = 120000;
  localparam int T_SETUP_OK_MS = 180000;
  localparam int T_SETUP_FAIL_MS = 30000;
  localparam int T_BLINK_MS = 125;
  localparam int T_SLOW_MS  = 500;
  localparam int T_FAST_MS  = 100;

  localparam int HOLD_W = 17;
  localparam int TMR_W  = 18;
  localparam int DB_W   = 5;
  localparam int BLK_W  = 9;

  // Buttons
  localparam int NBTN      = 4;
  localparam int BTN_HIGH  = 0;
  localparam int BTN_LOW   = 1;
  localparam int BTN_SETUP = 2;
  localparam int BTN_RESET = 3;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT  = 8'h08;
  localparam logic [7:0] ADDR_PROF = 8'h0C;

  // Control register fields
  localparam int CTRL_LOW_EN  = 0;
  localparam int CTRL_HIGH_EN = 1;
  localparam int CTRL_WDS     = 2;
  localparam int CTRL_FAULT   = 3;
  localparam int CTRL_W       = 4;
  localparam logic [3:0] CTRL_RST = 4'h3;

  // Event register fields
  localparam int EVT_SETUP    = 0;
  localparam int EVT_LOW_TOG  = 1;
  localparam int EVT_HIGH_TOG = 2;
  localparam int EVT_RESTORE  = 3;
  localparam int EVT_RECOVERY = 4;
  localparam int EVT_W        = 5;

  typedef enum logic [1:0] {INET_OFF, INET_UP, INET_FAIL} fpb_inet_t;
  typedef enum logic [1:0] {SU_IDLE, SU_OPEN, SU_OK, SU_FAIL} fpb_setup_t;
endpackage

// File: verilog/fpb_front_panel.sv
// Front panel button timing and status indicator controller
//
// Behaviour
// RULE1: Short high band press under 5 s opens a 2 minute setup window.
// RULE2: High band hold between 5 s and 10 s toggles high band radio.
// RULE3: Short low band press under 5 s opens a 2 minute setup window.
// RULE4: Low band hold between 5 s and 10 s toggles low band radio.
// RULE5: Setup button press under 2 s opens a 2 minute setup window.
// RULE6: Reset held 10 s requests factory defaults restore and reboot.
// RULE7: Reset held over 60 s enters firmware recovery boot instead.
// RULE8: Internet green steady when connected idle; stays lit after idle drop.
// RULE9: Internet green off when unpowered, in distribution mode, or no WAN.
// RULE10: Internet green blinks while connected with traffic.
// RULE11: Internet red when a connection attempt fails.
// RULE12: Other session drops turn internet off; failed reconnect turns red.
// RULE13: Wired uplink indicator on with link, off without, blinks on activity.
// RULE14: Each band indicator on when enabled, off disabled, blinks on data.
// RULE15: Setup indicator steady for 3 minutes after successful association.
// RULE16: Setup indicator slow blinks during association, off when idle.
// RULE17: Setup indicator fast blinks 30 seconds after failed association.
// RULE18: LAN indicators on with link, off without, blink on data.
// RULE19: USB indicator on with active device, off otherwise, blinks on data.
// RULE20: Power green when up, off when down, red on self-test or fault.
// RULE21: Reset loads defaults; profile write then overrides differing values.
// RULE22: Buttons synchronised, debounced, hold timed from press to release.
// RULE23: Slow and fast blink use distinct periods from a shared tick.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module fpb_front_panel
  import fpb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NBTN-1:0]  btnPress_b,
  input  wire logic             pwrGood,
  input  wire logic             postFail,
  input  wire logic             wanPresent,
  input  wire logic             ipUp,
  input  wire logic             ipFail,
  input  wire logic             ipTraffic,
  input  wire logic             dropIdle,
  input  wire logic             dropOther,
  input  wire logic             wanLink,
  input  wire logic             wanAct,
  input  wire logic             highBandAct,
  input  wire logic             lowBandAct,
  input  wire logic             setupOk,
  input  wire logic             setupFail,
  input  wire logic [3:0]       lanLink,
  input  wire logic [3:0]       lanAct,
  input  wire logic             usbActive,
  input  wire logic             usbXfer,
  output logic                  setupWindow,
  output logic                  highBandEn,
  output logic                  lowBandEn,
  output logic                  restoreReq,
  output logic                  recoveryBoot,
  output logic                  ledInetGreen,
  output logic                  ledInetRed,
  output logic                  ledWanGreen,
  output logic                  ledHighBand,
  output logic                  ledLowBand,
  output logic                  ledSetup,
  output logic [3:0]            ledLan,
  output logic                  ledUsb,
  output logic                  ledPwrGreen,
  output logic                  ledPwrRed
);

  // Millisecond tick and blink phases
  logic [31:0]      tickCnt_ff;
  logic             msTick;
  logic [BLK_W-1:0] blkCnt_ff;
  logic [BLK_W-1:0] slowCnt_ff;
  logic [BLK_W-1:0] fastCnt_ff;
  logic             blink_ff;
  logic             slow_ff;
  logic             fast_ff;

  assign msTick = ce && (tickCnt_ff == TICK_CYCLES - 1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_ff <= 32'h0;
    end else if (ce) begin
      tickCnt_ff <= msTick ? 32'h0 : tickCnt_ff + 32'h1;
    end
  end

  // One prescaled tick feeds three independent phase dividers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      blkCnt_ff  <= '0;
      slowCnt_ff <= '0;
      fastCnt_ff <= '0;
      blink_ff   <= 1'b0;
      slow_ff    <= 1'b0;
      fast_ff    <= 1'b0;
    end else if (msTick) begin
      blkCnt_ff  <= (blkCnt_ff == BLK_W'(T_BLINK_MS - 1)) ? '0
                    : blkCnt_ff + 1'b1;
      slowCnt_ff <= (slowCnt_ff == BLK_W'(T_SLOW_MS - 1)) ? '0
                    : slowCnt_ff + 1'b1; // RULE23
      fastCnt_ff <= (fastCnt_ff == BLK_W'(T_FAST_MS - 1)) ? '0
                    : fastCnt_ff + 1'b1; // RULE23
      if (blkCnt_ff == BLK_W'(T_BLINK_MS - 1)) begin
        blink_ff <= ~blink_ff;
      end
      if (slowCnt_ff == BLK_W'(T_SLOW_MS - 1)) begin
        slow_ff <= ~slow_ff;
      end
      if (fastCnt_ff == BLK_W'(T_FAST_MS - 1)) begin
        fast_ff <= ~fast_ff;
      end
    end
  end

  // Buttons: sync, debounce, hold timer
  logic [NBTN-1:0]   sync0_ff;
  logic [NBTN-1:0]   sync1_ff;
  logic [NBTN-1:0]   pressed_ff;
  logic [NBTN-1:0]   relEvt;
  logic [HOLD_W-1:0] hold_ff [NBTN];

  for (genvar g = 0; g < NBTN; g++) begin : g_btn
    logic [DB_W-1:0] dbCnt_ff;
    logic            dbDone;
    assign dbDone = msTick && (dbCnt_ff == DB_W'(T_DEBOUNCE_MS - 1));
    assign relEvt[g] = pressed_ff[g] && !sync1_ff[g] && dbDone; // RULE22

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        sync0_ff[g]   <= 1'b0;
        sync1_ff[g]   <= 1'b0;
        pressed_ff[g] <= 1'b0;
        dbCnt_ff      <= '0;
        hold_ff[g]    <= '0;
      end else if (ce) begin
        sync0_ff[g] <= ~btnPress_b[g]; // RULE22
        sync1_ff[g] <= sync0_ff[g];
        if (sync1_ff[g] == pressed_ff[g]) begin
          dbCnt_ff <= '0;
        end else if (dbDone) begin
          pressed_ff[g] <= sync1_ff[g];
          dbCnt_ff      <= '0;
        end else if (msTick) begin
          dbCnt_ff <= dbCnt_ff + 1'b1;
        end
        // Hold time counts from debounced press; saturates past recovery
        if (!pressed_ff[g]) begin
          hold_ff[g] <= '0;
        end else if (msTick &&
                     hold_ff[g] <= HOLD_W'(T_RECOVERY_MS)) begin
          hold_ff[g] <= hold_ff[g] + 1'b1; // RULE22
        end
      end
    end
  end

  // Actions chosen at debounced release
  logic highShort;
  logic highToggle;
  logic lowShort;
  logic lowToggle;
  logic setupShort;
  logic doRestore;
  logic doRecovery;
  logic setupStart;

  assign highShort  = relEvt[BTN_HIGH] &&
                      hold_ff[BTN_HIGH] < HOLD_W'(T_BAND_SHORT_MS); // RULE1
  assign highToggle = relEvt[BTN_HIGH] &&
                      hold_ff[BTN_HIGH] > HOLD_W'(T_BAND_SHORT_MS) &&
                      hold_ff[BTN_HIGH] < HOLD_W'(T_BAND_LONG_MS); // RULE2
  assign lowShort   = relEvt[BTN_LOW] &&
                      hold_ff[BTN_LOW] < HOLD_W'(T_BAND_SHORT_MS); // RULE3
  assign lowToggle  = relEvt[BTN_LOW] &&
                      hold_ff[BTN_LOW] > HOLD_W'(T_BAND_SHORT_MS) &&
                      hold_ff[BTN_LOW] < HOLD_W'(T_BAND_LONG_MS); // RULE4
  assign setupShort = relEvt[BTN_SETUP] &&
                      hold_ff[BTN_SETUP] < HOLD_W'(T_SETUP_PRESS_MS); // RULE5
  assign doRestore  = relEvt[BTN_RESET] &&
                      hold_ff[BTN_RESET] >= HOLD_W'(T_RESTORE_MS) &&
                      hold_ff[BTN_RESET] <= HOLD_W'(T_RECOVERY_MS); // RULE6
  assign doRecovery = relEvt[BTN_RESET] &&
                      hold_ff[BTN_RESET] > HOLD_W'(T_RECOVERY_MS); // RULE7
  assign setupStart = highShort || lowShort || setupShort;

  // APB slave: one wait-free access phase after each setup cycle
  logic             accRdy_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [EVT_W-1:0]  evt_ff;
  logic              restore_ff;
  logic              recovery_ff;
  logic              selCtrl;
  logic              selStat;
  logic              selEvt;
  logic              selProf;
  logic              mapped;
  logic              wrEn;
  logic              rdLatch;
  logic [31:0]       rdMux;
  logic [31:0]       statWord;
  logic [EVT_W-1:0]  evtSet;
  logic              evtClr;
  fpb_inet_t         inet_ff;
  fpb_setup_t        setup_ff;

  assign selCtrl = (paddr == ADDR_CTRL);
  assign selStat = (paddr == ADDR_STAT);
  assign selEvt  = (paddr == ADDR_EVT);
  assign selProf = (paddr == ADDR_PROF);
  assign mapped  = selCtrl || selStat || selEvt || selProf;
  assign pready  = ce && accRdy_ff;
  assign pslverr = pready && psel && penable && !mapped;
  assign wrEn    = pready && psel && penable && pwrite && mapped;
  assign rdLatch = ce && psel && !penable;

  assign statWord = {20'h0, recovery_ff, restore_ff, pressed_ff,
                     2'(setup_ff), 2'(inet_ff), 2'b00};
  assign rdMux = selCtrl ? {28'h0, ctrl_ff}
               : selStat ? statWord
               : selEvt  ? {27'h0, evt_ff}
               : selProf ? {28'h0, ctrl_ff}
               : 32'h0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      accRdy_ff <= 1'b0;
      prdata    <= 32'h0;
    end else if (ce) begin
      accRdy_ff <= psel && !(penable && accRdy_ff);
      if (rdLatch) begin
        prdata <= rdMux;
      end
    end
  end

  // Control: defaults at reset, profile write overrides radio enables
  logic [CTRL_W-1:0] nxt_ctrl;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrEn && selCtrl) begin
      nxt_ctrl = pwdata[CTRL_W-1:0];
    end else if (wrEn && selProf) begin
      nxt_ctrl[CTRL_LOW_EN]  = pwdata[CTRL_LOW_EN]; // RULE21
      nxt_ctrl[CTRL_HIGH_EN] = pwdata[CTRL_HIGH_EN]; // RULE21
    end
    if (highToggle) begin
      nxt_ctrl[CTRL_HIGH_EN] = ~ctrl_ff[CTRL_HIGH_EN]; // RULE2
    end
    if (lowToggle) begin
      nxt_ctrl[CTRL_LOW_EN] = ~ctrl_ff[CTRL_LOW_EN]; // RULE4
    end
  end

  // Sticky events; a new event beats a write-one-to-clear
  assign evtClr = wrEn && selEvt;
  assign evtSet = {doRecovery, doRestore, highToggle, lowToggle, setupStart};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff     <= CTRL_RST; // RULE21
      evt_ff      <= '0;
      restore_ff  <= 1'b0;
      recovery_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      evt_ff  <= (evt_ff & ~(evtClr ? pwdata[EVT_W-1:0] : '0)) | evtSet;
      restore_ff <= doRestore && !recovery_ff; // RULE6
      if (doRecovery) begin
        recovery_ff <= 1'b1; // RULE7
      end
    end
  end

  assign highBandEn   = ctrl_ff[CTRL_HIGH_EN];
  assign lowBandEn    = ctrl_ff[CTRL_LOW_EN];
  assign restoreReq   = restore_ff;
  assign recoveryBoot = recovery_ff;

  // Internet connection state
  fpb_inet_t nxt_inet;

  always_comb begin
    nxt_inet = inet_ff;
    case (inet_ff)
      INET_OFF: begin
        if (ipFail) begin
          nxt_inet = INET_FAIL; // RULE11
        end else if (ipUp) begin
          nxt_inet = INET_UP;
        end
      end
      INET_UP: begin
        if (dropOther) begin
          nxt_inet = INET_OFF; // RULE12
        end else if (dropIdle) begin
          nxt_inet = INET_UP; // RULE8
        end else if (ipFail) begin
          nxt_inet = INET_FAIL;
        end
      end
      default: begin
        if (ipUp) begin
          nxt_inet = INET_UP;
        end
      end
    endcase
  end

  // Setup session: window, success hold, failure blink
  fpb_setup_t       nxt_setup;
  logic [TMR_W-1:0] setupTmr_ff;
  logic [TMR_W-1:0] nxt_setupTmr;
  logic             tmrDone;

  assign tmrDone = msTick && (setupTmr_ff == '0);

  always_comb begin
    nxt_setup    = setup_ff;
    nxt_setupTmr = (msTick && setupTmr_ff != '0) ? setupTmr_ff - 1'b1
                   : setupTmr_ff;
    if (setupStart) begin
      nxt_setup    = SU_OPEN;
      nxt_setupTmr = TMR_W'(T_WINDOW_MS - 1); // RULE1 RULE3 RULE5
    end else begin
      case (setup_ff)
        SU_OPEN: begin
          if (setupOk) begin
            nxt_setup    = SU_OK;
            nxt_setupTmr = TMR_W'(T_SETUP_OK_MS - 1); // RULE15
          end else if (setupFail || tmrDone) begin
            nxt_setup    = SU_FAIL;
            nxt_setupTmr = TMR_W'(T_SETUP_FAIL_MS - 1); // RULE17
          end
        end
        SU_OK, SU_FAIL: begin
          if (tmrDone) begin
            nxt_setup = SU_IDLE;
          end
        end
        default: begin
          nxt_setup = SU_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      inet_ff     <= INET_OFF;
      setup_ff    <= SU_IDLE;
      setupTmr_ff <= '0;
    end else if (ce) begin
      inet_ff     <= nxt_inet;
      setup_ff    <= nxt_setup;
      setupTmr_ff <= nxt_setupTmr;
    end
  end

  assign setupWindow = (setup_ff == SU_OPEN);

  // Indicator drive, registered
  logic       inetLit;
  logic       pwrBad;
  logic [3:0] nxt_lan;
  logic [12:0] nxt_led;
  logic [12:0] led_ff;

  // An idle-timeout drop leaves the state up, so the lamp stays lit
  assign inetLit = pwrGood && (inet_ff == INET_UP) &&
                   !ctrl_ff[CTRL_WDS] && wanPresent; // RULE8 RULE9
  assign pwrBad  = postFail || ctrl_ff[CTRL_FAULT];

  for (genvar p = 0; p < 4; p++) begin : g_lan
    assign nxt_lan[p] = lanLink[p] && (lanAct[p] ? blink_ff : 1'b1); // RULE18
  end

  always_comb begin
    nxt_led = '0;
    nxt_led[0] = inetLit && (ipTraffic ? blink_ff : 1'b1); // RULE10
    nxt_led[1] = pwrGood && (inet_ff == INET_FAIL); // RULE11 RULE12
    nxt_led[2] = wanLink && (wanAct ? blink_ff : 1'b1); // RULE13
    nxt_led[3] = ctrl_ff[CTRL_HIGH_EN] &&
                 (highBandAct ? blink_ff : 1'b1); // RULE14
    nxt_led[4] = ctrl_ff[CTRL_LOW_EN] &&
                 (lowBandAct ? blink_ff : 1'b1); // RULE14
    case (setup_ff)
      SU_OPEN: nxt_led[5] = slow_ff; // RULE16
      SU_OK:   nxt_led[5] = 1'b1; // RULE15
      SU_FAIL: nxt_led[5] = fast_ff; // RULE17
      default: nxt_led[5] = 1'b0; // RULE16
    endcase
    nxt_led[9:6] = nxt_lan;
    nxt_led[10]  = usbActive && (usbXfer ? blink_ff : 1'b1); // RULE19
    nxt_led[11]  = pwrGood && !pwrBad; // RULE20
    nxt_led[12]  = pwrGood && pwrBad; // RULE20
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      led_ff <= '0;
    end else if (ce) begin
      led_ff <= nxt_led;
    end
  end

  assign ledInetGreen = led_ff[0];
  assign ledInetRed   = led_ff[1];
  assign ledWanGreen  = led_ff[2];
  assign ledHighBand  = led_ff[3];
  assign ledLowBand   = led_ff[4];
  assign ledSetup     = led_ff[5];
  assign ledLan       = led_ff[9:6];
  assign ledUsb       = led_ff[10];
  assign ledPwrGreen  = led_ff[11];
  assign ledPwrRed    = led_ff[12];

endmodule

// File: sim/fpb_front_panel_sva.sv
// Port-level assertions for the front panel controller
`timescale 1ns/1ps
module fpb_front_panel_sva
  import fpb_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst_b,
  input wire logic            ce,
  input wire logic [NBTN-1:0] btnPress_b,
  input wire logic            pwrGood,
  input wire logic            postFail,
  input wire logic            wanPresent,
  input wire logic            ipFail,
  input wire logic            wanLink,
  input wire logic            wanAct,
  input wire logic            highBandAct,
  input wire logic [3:0]      lanLink,
  input wire logic [3:0]      lanAct,
  input wire logic            usbActive,
  input wire logic            usbXfer,
  input wire logic            highBandEn,
  input wire logic            restoreReq,
  input wire logic            recoveryBoot,
  input wire logic            ledInetGreen,
  input wire logic            ledInetRed,
  input wire logic            ledWanGreen,
  input wire logic            ledHighBand,
  input wire logic [3:0]      ledLan,
  input wire logic            ledUsb,
  input wire logic            ledPwrGreen,
  input wire logic            ledPwrRed
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_wan_steady;
    ce && pwrGood && wanLink && !wanAct;
  endsequence
  sequence s_fail_seen;
    ce && pwrGood && ipFail ##1 ce && pwrGood;
  endsequence
  sequence s_inet_dark;
    ce && (!pwrGood || !wanPresent);
  endsequence

  a_restore_one_pulse: assert property (restoreReq |=> !restoreReq)
    else $error("restore request longer than one cycle");
  a_restore_released: assert property (
    restoreReq |-> btnPress_b[BTN_RESET] && !recoveryBoot)
    else $error("restore fired while button held or in recovery");
  a_recovery_held: assert property (recoveryBoot |=> recoveryBoot)
    else $error("recovery boot state dropped");
  a_inet_dark: assert property (s_inet_dark |=> !ledInetGreen)
    else $error("internet green lit without power or uplink");
  a_inet_red: assert property (s_fail_seen |=> ledInetRed)
    else $error("internet red missing after failed attempt");
  a_wan_steady: assert property (s_wan_steady |=> ledWanGreen)
    else $error("uplink indicator dark with link up");
  a_wan_dark: assert property (ce && !wanLink && !wanAct |=> !ledWanGreen)
    else $error("uplink indicator lit without link");
  a_band_follow: assert property (
    ce && pwrGood && !highBandAct |=> ledHighBand == $past(highBandEn))
    else $error("band indicator disagrees with enable");
  a_lan_level: assert property (
    ce && pwrGood |=> ((ledLan ^ $past(lanLink)) & ~$past(lanAct)) == 4'h0)
    else $error("port indicator disagrees with link");
  a_usb_level: assert property (
    ce && pwrGood && !usbXfer |=> ledUsb == $past(usbActive))
    else $error("usb indicator disagrees with attach state");
  a_power_red: assert property (ce && pwrGood && postFail |=> ledPwrRed)
    else $error("power red missing on self-test failure");
  a_power_down: assert property (
    ce && !pwrGood |=> !ledPwrGreen && !ledPwrRed)
    else $error("power indicator lit while powered down");
endmodule

// File: sim/fpb_panel_model.sv
// Push button panel model driving active-low button levels
`timescale 1ns/1ps
module fpb_panel_model
  import fpb_pkg::*;
(
  input  wire logic            mclk,
  output logic      [NBTN-1:0] btnPress_b
);
  // Released buttons return high through the panel pull-ups
  initial btnPress_b = '1;
  task automatic hold(input int b, input int n);
    @(posedge mclk);
    btnPress_b[b] <= 1'h0;
    repeat (n) @(posedge mclk);
    btnPress_b[b] <= 1'h1;
  endtask
endmodule

// File: sim/fpb_front_panel_test.sv
// Self-checking bench for the front panel controller
`timescale 1ns/1ps
module fpb_front_panel_test
  import fpb_pkg::*;
;
  logic        mclk = 1'h0, rst_b = 1'h0, ce = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  // ipUp ipFail dropIdle dropOther setupOk setupFail
  logic [5:0]  ev = 6'h00;
  // pwrGood postFail wanPresent ipTraffic wanLink wanAct
  // highBandAct lowBandAct usbActive usbXfer
  logic [9:0]  lv = 10'h000;
  logic [3:0]  lanLink = 4'h0, lanAct = 4'h0;
  wire  [NBTN-1:0] btnPress_b;
  logic [31:0] prdata;
  logic [3:0]  ledLan;
  logic pready, pslverr, setupWindow, highBandEn, lowBandEn, restoreReq;
  logic recoveryBoot, ledInetGreen, ledInetRed, ledWanGreen, ledHighBand;
  logic ledLowBand, ledSetup, ledUsb, ledPwrGreen, ledPwrRed;
  int   mismatches = 0, total_checks = 0, cyc = 0, restores = 0;
  wire  [12:0] leds = {ledInetGreen, ledInetRed, ledWanGreen, ledHighBand,
    ledLowBand, ledSetup, ledLan, ledUsb, ledPwrGreen, ledPwrRed};

  // One tick per clock keeps the minute-scale holds inside the run
  fpb_front_panel #(.TICK_CYCLES(1)) fpb_front_panel_inst (
    .mclk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .btnPress_b, .pwrGood(lv[9]), .postFail(lv[8]),
    .wanPresent(lv[7]), .ipUp(ev[5]), .ipFail(ev[4]), .ipTraffic(lv[6]),
    .dropIdle(ev[3]), .dropOther(ev[2]), .wanLink(lv[5]), .wanAct(lv[4]),
    .highBandAct(lv[3]), .lowBandAct(lv[2]), .setupOk(ev[1]),
    .setupFail(ev[0]), .lanLink, .lanAct, .usbActive(lv[1]),
    .usbXfer(lv[0]), .setupWindow, .highBandEn, .lowBandEn, .restoreReq,
    .recoveryBoot, .ledInetGreen, .ledInetRed, .ledWanGreen, .ledHighBand,
    .ledLowBand, .ledSetup, .ledLan, .ledUsb, .ledPwrGreen, .ledPwrRed);
  fpb_panel_model fpb_panel_model_inst (.mclk, .btnPress_b);

  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (restoreReq === 1'h1)
      restores++;
    if (cyc == 98000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    r = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'h0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'h1, a, d, r);
  endtask
  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= 6'h00;
    repeat (4) @(posedge mclk);
  endtask
  // Debounce needs two sync stages plus twenty ticks after release
  task automatic press(input int b, input int c);
    fpb_panel_model_inst.hold(b, c);
    repeat (40) @(posedge mclk);
  endtask
  task automatic toggles(input int c, output logic [12:0] t);
    logic [12:0] p;
    t = 13'h0;
    repeat (c) begin
      p = leds;
      @(posedge mclk);
      t = t | (p ^ leds);
    end
  endtask
  // Cycles between two successive setup indicator changes
  task automatic gap(output int n);
    logic v;
    for (int i = 0; i < 2; i++) begin
      v = ledSetup;
      n = 0;
      while (ledSetup === v && n < 2000) begin
        @(posedge mclk);
        n++;
      end
    end
  endtask

  initial begin
    logic [12:0] t;
    int          n;
    repeat (16) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    chk(33'({highBandEn, lowBandEn}), 33'h3);
    rd(ADDR_CTRL, 33'h3);
    rd(8'h10, 33'h1_0000_0000);
    $display("test reset done");
    lv <= 10'h2A2;
    lanLink <= 4'hF;
    pulse(6'h20);
    chk(33'(leds), 33'h177E);
    lv <= 10'h2FF;
    lanAct <= 4'hF;
    toggles(300, t);
    chk(33'(t), 33'h177C);
    lv <= 10'h2A2;
    lanAct <= 4'h0;
    pulse(6'h08);
    chk(33'(ledInetGreen), 33'h1);
    pulse(6'h04);
    chk(33'({ledInetGreen, ledInetRed}), 33'h0);
    pulse(6'h10);
    chk(33'({ledInetGreen, ledInetRed}), 33'h1);
    lv <= 10'h222;
    pulse(6'h20);
    chk(33'(ledInetGreen), 33'h0);
    lv <= 10'h2A2;
    wr(ADDR_CTRL, 32'h7);
    pulse(6'h20);
    chk(33'(ledInetGreen), 33'h0);
    wr(ADDR_CTRL, 32'hB);
    pulse(6'h00);
    chk(33'(ledPwrRed), 33'h1);
    wr(ADDR_CTRL, 32'h3);
    lv <= 10'h3A2;
    pulse(6'h00);
    chk(33'(ledPwrRed), 33'h1);
    lv <= 10'h0A2;
    pulse(6'h00);
    chk(33'({ledPwrGreen, ledPwrRed}), 33'h0);
    lv <= 10'h2A2;
    $display("test indicators done");
    press(BTN_HIGH, 5);
    rd(ADDR_EVT, 33'h0);
    press(BTN_HIGH, 100);
    chk(33'(setupWindow), 33'h1);
    rd(ADDR_EVT, 33'h1);
    wr(ADDR_EVT, 32'h1F);
    gap(n);
    chk(33'(n), 33'h1F4);
    press(BTN_LOW, 100);
    rd(ADDR_EVT, 33'h1);
    wr(ADDR_EVT, 32'h1F);
    press(BTN_SETUP, 100);
    rd(ADDR_EVT, 33'h1);
    pulse(6'h02);
    toggles(1100, t);
    chk(33'({t[7], ledSetup}), 33'h1);
    press(BTN_SETUP, 100);
    pulse(6'h01);
    gap(n);
    chk(33'(n), 33'h64);
    $display("test short presses done");
    wr(ADDR_EVT, 32'h1F);
    press(BTN_HIGH, 7000);
    chk(33'(highBandEn), 33'h0);
    rd(ADDR_EVT, 33'h4);
    press(BTN_LOW, 7000);
    chk(33'(lowBandEn), 33'h0);
    rd(ADDR_EVT, 33'h6);
    wr(ADDR_PROF, 32'h3);
    chk(33'({highBandEn, lowBandEn}), 33'h3);
    rd(ADDR_CTRL, 33'h3);
    wr(ADDR_EVT, 32'h1F);
    press(BTN_RESET, 12000);
    chk(33'(restores), 33'h1);
    rd(ADDR_EVT, 33'h8);
    press(BTN_RESET, 61000);
    chk(33'({restores[1:0], recoveryBoot}), 33'h3);
    rd(ADDR_EVT, 33'h18);
    rd(ADDR_STAT, 33'h804);
    $display("test long holds done");
    give_verdict();
  end
endmodule

bind fpb_front_panel fpb_front_panel_sva fpb_front_panel_sva_inst (
  .mclk, .rst_b, .ce, .btnPress_b, .pwrGood, .postFail, .wanPresent,
  .ipFail, .wanLink, .wanAct, .highBandAct, .lanLink, .lanAct, .usbActive,
  .usbXfer, .highBandEn, .restoreReq, .recoveryBoot, .ledInetGreen,
  .ledInetRed, .ledWanGreen, .ledHighBand, .ledLan, .ledUsb, .ledPwrGreen,
  .ledPwrRed);
